// ---- dv/qec_encoder_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Incremental encoder on the motor shaft
// ----------------------------------------
module qec_encoder_model (
  input wire logic i_mclk,
  output logic o_phase_a,
  output logic o_phase_b,
  output logic o_index
);
  int gap = 6; // Clocks each new level holds, raise for a slow shaft
  initial begin
    o_phase_a = 1'b0;
    o_phase_b = 1'b0;
    o_index = 1'b0;
  end
  // Wait out the hold time of a level
  task automatic hold(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : hold
  // Quadrature steps, A leads B when forward
  task automatic step(input logic fwd, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_mclk);
      if ((o_phase_a == o_phase_b) == fwd) o_phase_a <= ~o_phase_a;
      else o_phase_b <= ~o_phase_b;
      hold(gap);
    end
  endtask : step
  // Raw pin levels, used as timer clock and direction
  task automatic set(input logic a, input logic b);
    @(posedge i_mclk);
    o_phase_a <= a;
    o_phase_b <= b;
    hold(gap);
  endtask : set
  // Index pulse, only ever given with both phases low
  task automatic index_pulse;
    if (!o_phase_a && !o_phase_b) begin
      @(posedge i_mclk);
      o_index <= 1'b1;
      hold(gap);
      o_index <= 1'b0;
      hold(gap);
    end
  endtask : index_pulse
  // Two-clock spike on phase A
  task automatic glitch;
    @(posedge i_mclk);
    o_phase_a <= ~o_phase_a;
    hold(2);
    o_phase_a <= ~o_phase_a;
    hold(gap);
  endtask : glitch
endmodule : qec_encoder_model

// ---- dv/test_quadrature_encoder_counter.sv ----
`timescale 1ns/1ps
module test_quadrature_encoder_counter;
  localparam logic [11:0] CTRL = qec_pkg::IDX_CTRL;
  localparam logic [11:0] FILT = qec_pkg::IDX_FILT;
  localparam logic [11:0] POS = qec_pkg::IDX_POS;
  localparam logic [11:0] MAX = qec_pkg::IDX_MAX;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic direction;
  logic irq;
  logic pa;
  logic pb;
  logic px;
  logic [31:0] r;
  logic e;
  int compares = 0;
  int miscompares = 0;
  int irqs = 0;
  // ----------------------------------------
  // Clock, parts and event counting
  // ----------------------------------------
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (irq === 1'b1) irqs <= irqs + 1;
  qec_encoder_model qec_encoder_model_inst (.i_mclk(mclk), .o_phase_a(pa), .o_phase_b(pb), .o_index(px));
  qec_top qec_top_inst (.i_mclk(mclk), .i_rst_n(rst_n), .i_sleep(sleep), .i_phase_a_in(pa),
    .i_phase_b_in(pb), .i_index_in(px), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_direction(direction), .o_irq_pulse(irq));
  // ----------------------------------------
  // Checks, bus cycles and closing report
  // ----------------------------------------
  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic irq_chk(input int exp);
    compares++;
    if (irqs != exp) begin
      miscompares++;
      $display("BAD t=%0t event count %0d exp %0d", $time, irqs, exp);
    end
  endtask : irq_chk
  // Setup, then access held until pready is seen
  task automatic acc(input logic w, input logic [11:0] idx, input logic [15:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {18'h0, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      $display("BAD t=%0t no pready", $time);
      miscompares++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc
  task automatic wr(input logic [11:0] idx, input logic [15:0] d);
    acc(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [11:0] idx, input logic [15:0] exp);
    acc(1'b0, idx, 16'h0000);
    cmp(r, {16'h0000, exp}, "read data");
    cmp({31'h0, e}, 32'h0000_0000, "read error");
  endtask : rd
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(CTRL, 16'h0000);
    rd(FILT, 16'h0000);
    rd(POS, 16'h0000);
    rd(MAX, 16'hFFFF);
    acc(1'b0, 12'h0130, 16'h0000);
    cmp({31'h0, e}, 32'h0000_0001, "unmapped error");
    $display("test reset values done");
    wr(CTRL, 16'h0600);
    qec_encoder_model_inst.step(1'b1, 5);
    rd(POS, 16'h0005);
    cmp({31'h0, direction}, 32'h0000_0001, "forward pin");
    rd(CTRL, 16'h0E00);
    qec_encoder_model_inst.step(1'b0, 2);
    rd(POS, 16'h0003);
    cmp({31'h0, direction}, 32'h0000_0000, "reverse pin");
    $display("test x4 counting done");
    wr(CTRL, 16'h0604);
    qec_encoder_model_inst.step(1'b1, 5);
    wr(FILT, 16'h0200);
    qec_encoder_model_inst.index_pulse();
    rd(POS, 16'h0008);
    irq_chk(0);
    wr(FILT, 16'h0000);
    qec_encoder_model_inst.index_pulse();
    rd(POS, 16'h0000);
    irq_chk(1);
    wr(CTRL, 16'h0600);
    qec_encoder_model_inst.step(1'b1, 4);
    qec_encoder_model_inst.index_pulse();
    rd(POS, 16'h0004);
    irq_chk(2);
    $display("test index done");
    wr(POS, 16'h0000);
    qec_encoder_model_inst.step(1'b0, 1);
    rd(CTRL, 16'h8600);
    irq_chk(3);
    qec_encoder_model_inst.step(1'b0, 1);
    rd(POS, 16'hFFFE);
    rd(CTRL, 16'h8600);
    irq_chk(3);
    wr(CTRL, 16'h0600);
    rd(CTRL, 16'h0600);
    wr(FILT, 16'h0100);
    wr(POS, 16'h0000);
    qec_encoder_model_inst.step(1'b0, 1);
    rd(CTRL, 16'h8600);
    irq_chk(3);
    $display("test count error done");
    wr(FILT, 16'h0000);
    wr(CTRL, 16'h0400);
    wr(POS, 16'h0010);
    qec_encoder_model_inst.step(1'b1, 4);
    rd(POS, 16'h0012);
    wr(MAX, 16'h0003);
    wr(POS, 16'h0003);
    wr(CTRL, 16'h0700);
    qec_encoder_model_inst.step(1'b1, 1);
    rd(POS, 16'h0000);
    qec_encoder_model_inst.step(1'b0, 1);
    rd(POS, 16'h0003);
    irq_chk(5);
    $display("test x2 and limit done");
    wr(CTRL, 16'h0101);
    rd(POS, 16'h0003);
    qec_encoder_model_inst.set(1'b0, 1'b1);
    qec_encoder_model_inst.set(1'b1, 1'b1);
    rd(POS, 16'h0000);
    irq_chk(6);
    qec_encoder_model_inst.set(1'b0, 1'b1);
    qec_encoder_model_inst.set(1'b1, 1'b1);
    rd(POS, 16'h0001);
    qec_encoder_model_inst.set(1'b0, 1'b0);
    qec_encoder_model_inst.set(1'b1, 1'b0);
    rd(POS, 16'h0000);
    wr(CTRL, 16'h0900);
    qec_encoder_model_inst.set(1'b0, 1'b0);
    qec_encoder_model_inst.set(1'b1, 1'b0);
    rd(POS, 16'h0001);
    sleep <= 1'b1;
    qec_encoder_model_inst.set(1'b0, 1'b0);
    qec_encoder_model_inst.set(1'b1, 1'b0);
    sleep <= 1'b0;
    rd(POS, 16'h0001);
    $display("test timer and sleep done");
    wr(CTRL, 16'h0500);
    wr(POS, 16'h0003);
    qec_encoder_model_inst.step(1'b1, 2);
    rd(POS, 16'h0000);
    irq_chk(7);
    qec_encoder_model_inst.step(1'b1, 1);
    rd(POS, 16'h0000);
    wr(CTRL, 16'h0404);
    wr(POS, 16'h0005);
    wr(FILT, 16'h0600);
    qec_encoder_model_inst.index_pulse();
    rd(POS, 16'h0005);
    irq_chk(7);
    wr(FILT, 16'h0400);
    qec_encoder_model_inst.index_pulse();
    rd(POS, 16'h0000);
    irq_chk(8);
    $display("test x2 modes done");
    wr(CTRL, 16'h0000);
    wr(FILT, 16'h00B0);
    qec_encoder_model_inst.gap = 40;
    qec_encoder_model_inst.hold(40);
    wr(CTRL, 16'h0600);
    wr(POS, 16'h0000);
    qec_encoder_model_inst.glitch();
    rd(POS, 16'h0000);
    qec_encoder_model_inst.step(1'b1, 1);
    rd(POS, 16'h0001);
    irq_chk(8);
    $display("test filter done");
    conclude();
  end
endmodule : test_quadrature_encoder_counter

// ---- hdl/qec_pkg.sv ----
package qec_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_CTRL = 12'h0122;
  localparam logic [11:0] IDX_FILT = 12'h0124;
  localparam logic [11:0] IDX_POS = 12'h0126;
  localparam logic [11:0] IDX_MAX = 12'h0128;
  localparam int ADDR_W = 14;

  // ----------------------------------------------------------------
  // encoder_control_reg fields
  // ----------------------------------------------------------------
  localparam int CTRL_COUNT_ERROR_FLAG = 15;
  localparam int CTRL_DIR = 11;
  localparam int CTRL_MODE_HI = 10;
  localparam int CTRL_MODE_LO = 8;
  localparam int CTRL_IDXRES = 2;
  localparam int CTRL_DIRSRC = 0;

  // ----------------------------------------------------------------
  // filter_control_reg fields
  // ----------------------------------------------------------------
  localparam int FILT_IMV_HI = 10;
  localparam int FILT_IMV_LO = 9;
  localparam int FILT_COUNT_ERROR_IRQ_DISABLE = 8;
  localparam int FILT_EN = 7;
  localparam int FILT_DIV_HI = 6;
  localparam int FILT_DIV_LO = 4;

  // ----------------------------------------------------------------
  // Modes of mode_select_field
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_TIMER = 3'h1;
  localparam logic [2:0] MODE_X2_IDX = 3'h4;
  localparam logic [2:0] MODE_X2_MAX = 3'h5;
  localparam logic [2:0] MODE_X4_IDX = 3'h6;
  localparam logic [2:0] MODE_X4_MAX = 3'h7;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_FILT = 16'h0000;
  localparam logic [15:0] RST_POS = 16'h0000;
  localparam logic [15:0] RST_MAX = 16'hFFFF;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  localparam int FILT_STAGES = 3;
  localparam int PRESC_W = 7;

endpackage : qec_pkg

// ---- hdl/qec_top.sv ----
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
// What this block does
// - A leading B decodes forward, A lagging B decodes reverse.
// - In modes 110/100 count reaching 0xFFFF or limit+1 sets error flag and interrupt.
// - count_error_irq_disable at filter bit 8 suppresses the count error interrupt.
// - After an error counting continues; the 16-bit wrap from 0xFFFF to 0 raises no interrupt unless the limit is 0xFFFF.
// - count_error_flag at control bit 15 is read/write, sticky until software clears.
// - index_reset_enable applies only in modes 100/110; index then clears count.
// - With index_reset_enable low the index leaves the count alone.
// - Index reset needs phase states matching index_match_value at filter bits 10:9.
// - In x4 the match upper bit is phase B level, lower bit phase A.
// - In x2 upper bit picks phase (0 A, 1 B), lower bit its level.
// - In index modes the interrupt comes from index detection and count errors, not wrap.
// - Direction drives a pin and reads back at control bit 11.
// - Modes 100/101 count both edges of A only; B gives direction.
// - Modes 110/111 count every edge of A and B.
// - Filter output changes only after three equal filter-clock samples.
// - Filter clock divides the system clock by 2 to the power filter_clock_div at bits 6:4.
// - Filtered inputs used only when filter_enable is 1; filters off after reset.
// - Mode 001 is a 16-bit timer on phase A; limit is the period.
// - Mode switches leave the count unchanged.
// - Timer direction from phase B when source select is 1, else direction_flag.
// - Timer clock is always synchronised to the system clock.
// - Counter, filters, direction and interrupts halt while sleep is asserted; APB accesses still work.
module qec_top (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_sleep,
  input wire logic i_phase_a_in,
  input wire logic i_phase_b_in,
  input wire logic i_index_in,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_direction,
  output logic o_irq_pulse
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Terminal count of the filter prescaler for a divide field
  function automatic logic [qec_pkg::PRESC_W-1:0] div_limit(input logic [2:0] sel);
    logic [qec_pkg::PRESC_W:0] one;
    one = {{qec_pkg::PRESC_W{1'b0}}, 1'b1} << sel;
    div_limit = one[qec_pkg::PRESC_W-1:0] - {{(qec_pkg::PRESC_W-1){1'b0}}, 1'b1};
  endfunction : div_limit

  // Register index from a byte address
  function automatic logic [11:0] reg_index(input logic [31:0] addr);
    reg_index = addr[13:2];
  endfunction : reg_index

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic count_error_flag_r;
  logic dir_r;
  logic [2:0] mode_r;
  logic idxres_r;
  logic dirsrc_r;
  logic [1:0] imv_r;
  logic count_error_irq_disable_r;
  logic filt_en_r;
  logic [2:0] fdiv_r;
  logic [15:0] pos_r;
  logic [15:0] max_r;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] s0_r;
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] filt_r;
  logic [2:0] prev_r;
  logic [qec_pkg::PRESC_W-1:0] presc_r;
  logic tick_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic [11:0] idx = reg_index(i_paddr);
  wire logic addr_hi_zero = (i_paddr[31:qec_pkg::ADDR_W] == '0) && (i_paddr[1:0] == 2'b00);
  wire logic hit_ctrl = addr_hi_zero && (idx == qec_pkg::IDX_CTRL);
  wire logic hit_filt = addr_hi_zero && (idx == qec_pkg::IDX_FILT);
  wire logic hit_pos = addr_hi_zero && (idx == qec_pkg::IDX_POS);
  wire logic hit_max = addr_hi_zero && (idx == qec_pkg::IDX_MAX);
  wire logic hit_any = hit_ctrl || hit_filt || hit_pos || hit_max;
  wire logic setup = i_psel && !i_penable;
  wire logic wr_acc = i_psel && i_penable && pready_r && i_pwrite && hit_any;
  wire logic wr_ctrl = wr_acc && hit_ctrl;
  wire logic wr_filt = wr_acc && hit_filt;
  wire logic wr_pos = wr_acc && hit_pos;
  wire logic wr_max = wr_acc && hit_max;

  // Read-back words
  wire logic [15:0] ctrl_word = {count_error_flag_r, 3'h0, dir_r, mode_r, 5'h00, idxres_r, 1'b0, dirsrc_r};
  wire logic [15:0] filt_word = {5'h00, imv_r, count_error_irq_disable_r, filt_en_r, fdiv_r, 4'h0};
  wire logic [15:0] rd_word = hit_ctrl ? ctrl_word :
                              hit_filt ? filt_word :
                              hit_pos ? pos_r :
                              hit_max ? max_r : 16'h0000;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire logic enc_mode = mode_r[2];
  wire logic x4_mode = mode_r[2] && mode_r[1];
  wire logic idx_mode = (mode_r == qec_pkg::MODE_X2_IDX) || (mode_r == qec_pkg::MODE_X4_IDX);
  wire logic timer_mode = (mode_r == qec_pkg::MODE_TIMER);
  wire logic max_mode = (mode_r == qec_pkg::MODE_X2_MAX) || (mode_r == qec_pkg::MODE_X4_MAX) || timer_mode;

  // ----------------------------------------------------------------
  // Input selection and edge detection
  // ----------------------------------------------------------------
  // Filtered or raw synchronised inputs: bit0 A, bit1 B, bit2 index
  wire logic [2:0] sel_in = filt_en_r ? filt_r : sync2_r;
  wire logic pa = sel_in[0];
  wire logic pb = sel_in[1];
  wire logic pix = sel_in[2];
  wire logic a_edge = pa ^ prev_r[0];
  wire logic b_edge = pb ^ prev_r[1];
  wire logic ix_rise = pix && !prev_r[2];

  // Quadrature count pulses and direction
  wire logic cnt_ev = enc_mode && (a_edge || (x4_mode && b_edge));
  wire logic enc_up = a_edge ? (pa ^ pb) : !(pa ^ pb);

  // Index match on phase states
  wire logic match_x4 = (pb == imv_r[1]) && (pa == imv_r[0]);
  wire logic match_x2 = (imv_r[1] ? pb : pa) == imv_r[0];
  wire logic idx_match = x4_mode ? match_x4 : match_x2;
  wire logic idx_hit = idx_mode && ix_rise && idx_match;
  wire logic idx_clear = idx_hit && idxres_r;

  // Timer counts rising edges of the synchronised phase A
  wire logic tmr_tick = timer_mode && pa && !prev_r[0];
  wire logic tmr_up = dirsrc_r ? pb : dir_r;

  // Common step logic
  wire logic step = cnt_ev || tmr_tick;
  wire logic step_up = enc_mode ? enc_up : tmr_up;
  wire logic [15:0] pos_inc = pos_r + 16'h0001;
  wire logic [15:0] pos_dec = pos_r - 16'h0001;
  wire logic [15:0] max_p1 = max_r + 16'h0001;
  wire logic at_lim = step_up ? (pos_r == max_r) : (pos_r == 16'h0000);
  wire logic wrap_hit = step && max_mode && at_lim;
  wire logic [15:0] pos_step = wrap_hit ? (step_up ? 16'h0000 : max_r) : (step_up ? pos_inc : pos_dec);

  // Count error check in index modes only
  wire logic err_hit = step && idx_mode && !idx_clear &&
                       (step_up ? (pos_step == max_p1) : (pos_step == qec_pkg::ALL_ONES));

  // Next position: software write, sleep hold, index clear, step
  wire logic [15:0] pos_nxt = wr_pos ? i_pwdata[15:0] :
                              i_sleep ? pos_r :
                              idx_clear ? 16'h0000 :
                              step ? pos_step : pos_r;

  // Interrupt events: wrap in max modes, index in index modes, errors
  wire logic irq_nxt = !i_sleep && (wrap_hit || idx_hit || (err_hit && !count_error_irq_disable_r));

  // Error flag: hardware set wins over software clear
  wire logic count_error_flag_nxt = (!i_sleep && err_hit) || (wr_ctrl ? i_pwdata[qec_pkg::CTRL_COUNT_ERROR_FLAG] : count_error_flag_r);

  // Direction: decoded in encoder modes, written by software otherwise
  wire logic dir_nxt = i_sleep ? dir_r :
                       cnt_ev ? enc_up :
                       (wr_ctrl && !enc_mode) ? i_pwdata[qec_pkg::CTRL_DIR] : dir_r;

  // Filter sampling and three-sample agreement
  wire logic [2:0] stable = ~(s0_r ^ s1_r) & ~(s1_r ^ s2_r);
  wire logic [2:0] filt_nxt = (stable & s0_r) | (~stable & filt_r);
  wire logic tick_nxt = !i_sleep && (presc_r == div_limit(fdiv_r));
  wire logic [qec_pkg::PRESC_W-1:0] presc_nxt = (i_sleep) ? presc_r :
                                                 (tick_nxt ? '0 : presc_r + {{(qec_pkg::PRESC_W-1){1'b0}}, 1'b1});

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Two flops before any logic reads the pins
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {i_index_in, i_phase_b_in, i_phase_a_in};
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // Noise filters
  // ----------------------------------------------------------------
  // Prescaler and tick
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      presc_r <= '0;
      tick_r <= 1'b0;
    end else begin
      presc_r <= presc_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Sample shift and filtered output
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s0_r <= 3'h0;
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      filt_r <= 3'h0;
    end else if (tick_r && !i_sleep) begin
      s0_r <= sync2_r;
      s1_r <= s0_r;
      s2_r <= s1_r;
      filt_r <= filt_nxt;
    end
  end

  // Previous selected input levels
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      prev_r <= 3'h0;
    end else if (!i_sleep) begin
      prev_r <= sel_in;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Control fields written by software
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      mode_r <= qec_pkg::RST_CTRL[qec_pkg::CTRL_MODE_HI:qec_pkg::CTRL_MODE_LO];
      idxres_r <= qec_pkg::RST_CTRL[qec_pkg::CTRL_IDXRES];
      dirsrc_r <= qec_pkg::RST_CTRL[qec_pkg::CTRL_DIRSRC];
    end else if (wr_ctrl) begin
      mode_r <= i_pwdata[qec_pkg::CTRL_MODE_HI:qec_pkg::CTRL_MODE_LO];
      idxres_r <= i_pwdata[qec_pkg::CTRL_IDXRES];
      dirsrc_r <= i_pwdata[qec_pkg::CTRL_DIRSRC];
    end
  end

  // Filter control fields; filter disabled after reset
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      imv_r <= qec_pkg::RST_FILT[qec_pkg::FILT_IMV_HI:qec_pkg::FILT_IMV_LO];
      count_error_irq_disable_r <= qec_pkg::RST_FILT[qec_pkg::FILT_COUNT_ERROR_IRQ_DISABLE];
      filt_en_r <= qec_pkg::RST_FILT[qec_pkg::FILT_EN];
      fdiv_r <= qec_pkg::RST_FILT[qec_pkg::FILT_DIV_HI:qec_pkg::FILT_DIV_LO];
    end else if (wr_filt) begin
      imv_r <= i_pwdata[qec_pkg::FILT_IMV_HI:qec_pkg::FILT_IMV_LO];
      count_error_irq_disable_r <= i_pwdata[qec_pkg::FILT_COUNT_ERROR_IRQ_DISABLE];
      filt_en_r <= i_pwdata[qec_pkg::FILT_EN];
      fdiv_r <= i_pwdata[qec_pkg::FILT_DIV_HI:qec_pkg::FILT_DIV_LO];
    end
  end

  // Count limit
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      max_r <= qec_pkg::RST_MAX;
    end else if (wr_max) begin
      max_r <= i_pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Counter, flags and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pos_r <= qec_pkg::RST_POS;
      count_error_flag_r <= qec_pkg::RST_CTRL[qec_pkg::CTRL_COUNT_ERROR_FLAG];
      dir_r <= qec_pkg::RST_CTRL[qec_pkg::CTRL_DIR];
      irq_r <= 1'b0;
    end else begin
      pos_r <= pos_nxt;
      count_error_flag_r <= count_error_flag_nxt;
      dir_r <= dir_nxt;
      irq_r <= irq_nxt;
    end
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !hit_any;
      prdata_r <= (setup && !i_pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_direction = dir_r;
  assign o_irq_pulse = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  sequence seq_timer_wrap_up;
    tmr_tick && tmr_up && (pos_r == max_r) && !wr_pos && !i_sleep;
  endsequence

  sequence seq_idx_clear;
    idx_hit && idxres_r && !wr_pos && !i_sleep;
  endsequence

  a_count_error_flag_sticky: assert property (count_error_flag_r && !wr_ctrl |=> count_error_flag_r)
    else $error("count error flag dropped without a write");

  a_count_error_flag_set: assert property (err_hit && !i_sleep |=> count_error_flag_r && (o_irq_pulse == ($past(idx_hit) || !$past(count_error_irq_disable_r))))
    else $error("count error did not set flag or irq wrongly gated");

  a_idx_reset: assert property (seq_idx_clear |=> (pos_r == 16'h0000) && o_irq_pulse)
    else $error("index pulse did not clear the count");

  a_idx_noreset: assert property (idx_hit && !idxres_r && !step && !wr_pos |=> $stable(pos_r))
    else $error("index moved the count with reset disabled");

  a_timer_wrap: assert property (seq_timer_wrap_up |=> (pos_r == 16'h0000) && o_irq_pulse)
    else $error("timer period match missed");

  a_dir_decode: assert property (enc_mode && a_edge && !i_sleep |=> o_direction == ($past(pa) ^ $past(pb)))
    else $error("direction decode wrong");

  a_x2_ignore_b: assert property (mode_r[2] && !mode_r[1] && b_edge && !a_edge && !idx_hit && !wr_pos
                                  |=> $stable(pos_r))
    else $error("x2 mode counted a phase B edge");

  a_sleep_hold: assert property (i_sleep && !wr_pos |=> $stable(pos_r) && !o_irq_pulse)
    else $error("block moved during sleep");

  a_filter_hold: assert property (!tick_r |=> $stable(filt_r))
    else $error("filter changed without a filter tick");

  a_idx_wrap_quiet: assert property (idx_mode && step && !idx_hit && !err_hit |=> !o_irq_pulse)
    else $error("interrupt on plain count in index mode");

  a_mode_keep: assert property (wr_ctrl && !step && !idx_clear && !wr_pos |=> $stable(pos_r))
    else $error("mode write moved the count");

  a_count_error_irq_disable_quiet: assert property (err_hit && count_error_irq_disable_r && !idx_hit |=> !o_irq_pulse)
    else $error("count error interrupt not suppressed");

  a_apb_ready: assert property (setup |=> o_pready ##1 !o_pready)
    else $error("apb ready timing wrong");

endmodule : qec_top
